// ===== hw/spirq_dsport.sv
/*
 Interrupt engine of one downstream port: sticky sources, MSI or INTA.
 Assumes clears arrive as one-cycle strobes from the register slave.
*/
`timescale 1ns/100ps
module spirq_dsport (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    spirq_port_if.port       bus
);
    import spirq_pkg::*;

    typedef struct packed {
        logic [STS_W-1:0] sts;
        logic             cond_prev;
        logic             inta;
        logic             msi_fire;
    } spirq_port_st_t;

    spirq_port_st_t   st;
    spirq_port_st_t   st_nxt;
    logic             cond;
    logic             rise;
    logic             fall;
    logic             msi_en;
    logic             leg_dis;

    assign msi_en  = bus.ctrl[CTRL_MSI_EN];
    assign leg_dis = bus.ctrl[CTRL_LEG_DIS];
    assign cond    = |(st.sts & bus.ctrl[CTRL_IE_LSB +: STS_W]);
    assign rise    = cond & ~st.cond_prev;
    assign fall    = ~cond & st.cond_prev;

    always_comb begin
        st_nxt          = st;
        // A source event in the clearing cycle survives
        st_nxt.sts      = (st.sts & ~bus.clr) | bus.evt;
        st_nxt.msi_fire = rise & msi_en;
        st_nxt.cond_prev = cond;
        if (!bus.link_up) begin
            // Forget only the INTA edge, so a live source re-raises after link-up;
            // in MSI mode the edge is kept, else an MSI would fire every cycle
            st_nxt.inta      = 1'b0;
            st_nxt.cond_prev = cond & msi_en;
        end else if (rise && !msi_en && !leg_dis) begin
            st_nxt.inta = 1'b1;
        end else if (fall && !msi_en && !leg_dis) begin
            st_nxt.inta = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= st_nxt;
        end
    end

    assign bus.sts      = st.sts;
    assign bus.msi_fire = st.msi_fire;
    assign bus.inta     = st.inta;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_msi_rise;
        rise && msi_en |=> st.msi_fire;
    endproperty
    a_msi_rise: assert property (p_msi_rise) else $error("MSI missing on assertion");

    property p_no_msi_off;
        !msi_en |=> !st.msi_fire;
    endproperty
    a_no_msi_off: assert property (p_no_msi_off) else $error("MSI while disabled");

    property p_inta_set;
        rise && !msi_en && !leg_dis && bus.link_up |=> st.inta;
    endproperty
    a_inta_set: assert property (p_inta_set) else $error("INTA not asserted");

    property p_inta_hold;
        bus.link_up && (msi_en || leg_dis) |=> st.inta == $past(st.inta);
    endproperty
    a_inta_hold: assert property (p_inta_hold) else $error("INTA moved while inactive");

    property p_inta_clr;
        fall && !msi_en && !leg_dis |=> !st.inta;
    endproperty
    a_inta_clr: assert property (p_inta_clr) else $error("INTA not negated");

    property p_link_down;
        !bus.link_up |=> !st.inta ##1 !st.inta || bus.link_up;
    endproperty
    a_link_down: assert property (p_link_down) else $error("INTA kept on link down");
endmodule

// ===== hw/spirq_pkg.sv
/*
 Constants, encodings and types for the switch port interrupt signalling block.
 Assumes one core clock and a synchronous active-high reset shared by all files.
*/
package spirq_pkg;
    localparam int NUM_DS   = 4;
    localparam int NUM_WIRE = 4;
    localparam int ADDR_W   = 8;
    localparam int CTRL_W   = 5;
    localparam int STS_W    = 3;
    localparam int EV_W     = 4;

    // Per-port control fields
    localparam int CTRL_MSI_EN  = 0;
    localparam int CTRL_LEG_DIS = 1;
    localparam int CTRL_IE_LSB  = 2;

    // Per-port status fields, in the same order as the enables above
    localparam int STS_HP  = 0;
    localparam int STS_BW  = 1;
    localparam int STS_ABW = 2;

    // Interrupt event bits
    localparam int EV_MSI    = 0;
    localparam int EV_ASSERT = 1;
    localparam int EV_DEASRT = 2;
    localparam int EV_LINKDN = 3;

    // Register map
    localparam logic [ADDR_W-1:0] PORT_STRIDE  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PCTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PSTS     = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STS  = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h44;
    localparam logic [ADDR_W-1:0] OFS_AGG      = 8'h48;

    // Values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h00;
    localparam logic [EV_W-1:0]   IRQ_EN_RST = 4'h0;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_RESP = 2'b01
    } spirq_apb_st_t;
endpackage

// ===== hw/spirq_port_if.sv
/*
 Carrier between the top and one downstream port engine.
 Assumes the top drives control and strobes, the port returns its state.
*/
`timescale 1ns/100ps
interface spirq_port_if;
    logic [spirq_pkg::CTRL_W-1:0] ctrl;
    logic [spirq_pkg::STS_W-1:0]  evt;
    logic [spirq_pkg::STS_W-1:0]  clr;
    logic                         link_up;
    logic [spirq_pkg::STS_W-1:0]  sts;
    logic                         msi_fire;
    logic                         inta;

    modport top  (output ctrl, evt, clr, link_up, input sts, msi_fire, inta);
    modport port (input ctrl, evt, clr, link_up, output sts, msi_fire, inta);
endinterface

// ===== hw/spirq_remap.sv
/*
 Rotates a set of four virtual wires by a device number.
 Assumes the device number is fixed at elaboration.
*/
`timescale 1ns/100ps
module spirq_remap #(
    parameter int DEV = 0
) (
    input  wire logic [spirq_pkg::NUM_WIRE-1:0] wire_i,
    output logic      [spirq_pkg::NUM_WIRE-1:0] wire_o
);
    import spirq_pkg::*;

    for (genvar i = 0; i < NUM_WIRE; i++) begin : g_rot
        assign wire_o[(i + (DEV % NUM_WIRE)) % NUM_WIRE] = wire_i[i];
    end
endmodule

// ===== hw/spirq_top.sv
/*
 Switch interrupt signalling: downstream port engines, per-port wire state,
 upstream remap and aggregation, Assert/Deassert message and MSI issue, APB.
 Assumes message and MSI outputs are taken by the core in the pulse cycle.
*/
`timescale 1ns/100ps
module spirq_top (
    input  wire logic                                               ref_clk_i,
    input  wire logic                                               rst_i,
    input  wire logic                                               psel_i,
    input  wire logic                                               penable_i,
    input  wire logic                                               pwrite_i,
    input  wire logic [spirq_pkg::ADDR_W-1:0]                       paddr_i,
    input  wire logic [31:0]                                        pwdata_i,
    output logic      [31:0]                                        prdata_o,
    output logic                                                    pready_o,
    output logic                                                    pslverr_o,
    input  wire logic [spirq_pkg::NUM_DS-1:0]                       hp_evt_i,
    input  wire logic [spirq_pkg::NUM_DS-1:0]                       bw_mgmt_flag_i,
    input  wire logic [spirq_pkg::NUM_DS-1:0]                       autonomous_bw_flag_i,
    input  wire logic [spirq_pkg::NUM_DS-1:0]                       dl_up_i,
    input  wire logic [spirq_pkg::NUM_DS-1:0][spirq_pkg::NUM_WIRE-1:0] ext_intx_i,
    input  wire logic [spirq_pkg::NUM_WIRE-1:0]                     us_own_intx_i,
    output logic                                                    msi_req_o,
    output logic      [1:0]                                         msi_port_o,
    output logic                                                    intx_msg_o,
    output logic                                                    intx_assert_o,
    output logic      [1:0]                                         intx_wire_o,
    output logic      [spirq_pkg::NUM_DS*spirq_pkg::NUM_WIRE-1:0]   ds_intx_o,
    output logic      [spirq_pkg::NUM_WIRE-1:0]                     us_intx_o,
    output logic                                                    irq_o
);
    import spirq_pkg::*;

    typedef struct packed {
        spirq_apb_st_t                     apb;
        logic [31:0]                       prdata;
        logic                              slverr;
        logic [NUM_DS-1:0][CTRL_W-1:0]     ctrl;
        logic [NUM_DS-1:0]                 link;
        logic [NUM_DS-1:0][NUM_WIRE-1:0]   port_wire;
        logic [NUM_WIRE-1:0]               us_agg;
        logic [NUM_WIRE-1:0]               us_sent;
        logic                              msg;
        logic                              msg_asrt;
        logic [1:0]                        msg_wire;
        logic [NUM_DS-1:0]                 msi_pend;
        logic                              msi;
        logic [1:0]                        msi_port;
        logic [EV_W-1:0]                   ev_sts;
        logic [EV_W-1:0]                   ev_en;
        logic                              irq;
    } spirq_top_st_t;

    spirq_top_st_t                     st;
    spirq_top_st_t                     st_nxt;
    logic                              acc;
    logic                              commit;
    logic                              hit;
    logic [31:0]                       rdata;
    logic [NUM_DS-1:0][STS_W-1:0]      clr;
    logic [NUM_DS-1:0][STS_W-1:0]      sts;
    logic [NUM_DS-1:0]                 msi_fire;
    logic [NUM_DS-1:0]                 inta;
    logic [NUM_DS-1:0][NUM_WIRE-1:0]   remapped;
    logic [EV_W-1:0]                   ev;
    logic [EV_W-1:0]                   rd_clr;
    logic [NUM_WIRE-1:0]               diff;

    spirq_port_if pif[NUM_DS] ();

    // ************************************************************
    // Downstream ports
    // ************************************************************
    for (genvar g = 0; g < NUM_DS; g++) begin : g_port
        assign pif[g].ctrl    = st.ctrl[g];
        assign pif[g].evt     = {autonomous_bw_flag_i[g], bw_mgmt_flag_i[g], hp_evt_i[g]};
        assign pif[g].clr     = clr[g];
        assign pif[g].link_up = dl_up_i[g];
        assign sts[g]         = pif[g].sts;
        assign msi_fire[g]    = pif[g].msi_fire;
        assign inta[g]        = pif[g].inta;

        spirq_dsport u_port (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .bus       (pif[g])
        );

        // The device below is device zero on its own link, so only here is
        // the rotation applied
        spirq_remap #(.DEV(g)) u_remap (
            .wire_i (st.port_wire[g]),
            .wire_o (remapped[g])
        );
    end

    assign acc    = psel_i & penable_i;
    assign commit = acc & (st.apb == APB_RESP);
    assign diff   = st.us_agg ^ st.us_sent;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        int ws;
        int ps;
        ws     = 0;
        ps     = 0;
        st_nxt = st;
        hit    = 1'b0;
        rdata  = '0;
        clr    = '0;
        rd_clr = '0;

        // Register read mux
        for (int p = 0; p < NUM_DS; p++) begin
            if (paddr_i == ADDR_W'(p * PORT_STRIDE) + OFS_PCTRL) begin
                hit   = 1'b1;
                rdata = 32'(st.ctrl[p]);
            end
            if (paddr_i == ADDR_W'(p * PORT_STRIDE) + OFS_PSTS) begin
                hit   = 1'b1;
                rdata = 32'(sts[p]);
            end
        end
        if (paddr_i == OFS_IRQ_STS) begin
            hit   = 1'b1;
            rdata = 32'(st.ev_sts);
        end
        if (paddr_i == OFS_IRQ_EN) begin
            hit   = 1'b1;
            rdata = 32'(st.ev_en);
        end
        if (paddr_i == OFS_AGG) begin
            hit   = 1'b1;
            rdata = 32'({st.port_wire, st.us_agg});
        end

        // Read data is latched one cycle before the completing edge
        case (st.apb)
            APB_IDLE: begin
                if (acc) begin
                    st_nxt.apb    = APB_RESP;
                    st_nxt.prdata = pwrite_i ? 32'h0000_0000 : rdata;
                    st_nxt.slverr = ~hit;
                end
            end
            APB_RESP: begin
                st_nxt.apb    = APB_IDLE;
                st_nxt.prdata = 32'h0000_0000;
                st_nxt.slverr = 1'b0;
            end
            default: begin
                st_nxt.apb = APB_IDLE;
            end
        endcase

        if (commit && pwrite_i) begin
            for (int p = 0; p < NUM_DS; p++) begin
                if (paddr_i == ADDR_W'(p * PORT_STRIDE) + OFS_PCTRL) begin
                    st_nxt.ctrl[p] = pwdata_i[CTRL_W-1:0];
                end
                if (paddr_i == ADDR_W'(p * PORT_STRIDE) + OFS_PSTS) begin
                    clr[p] = pwdata_i[STS_W-1:0];
                end
            end
            if (paddr_i == OFS_IRQ_EN) begin
                st_nxt.ev_en = pwdata_i[EV_W-1:0];
            end
        end
        // Clear only what the reader saw; later events stay pending
        if (commit && !pwrite_i && paddr_i == OFS_IRQ_STS) begin
            rd_clr = st.prdata[EV_W-1:0];
        end

        // Per-port wire state, external and own INTA together
        st_nxt.link   = dl_up_i;
        st_nxt.us_agg = us_own_intx_i;
        for (int p = 0; p < NUM_DS; p++) begin
            st_nxt.port_wire[p] = dl_up_i[p] ?
                (ext_intx_i[p] | NUM_WIRE'(inta[p])) : '0;
            st_nxt.us_agg = st_nxt.us_agg | remapped[p];
        end

        // One message a cycle; the lowest changed wire goes first
        st_nxt.msg = 1'b0;
        for (int w = NUM_WIRE - 1; w >= 0; w--) begin
            if (diff[w]) begin
                ws = w;
            end
        end
        if (|diff) begin
            st_nxt.msg          = 1'b1;
            st_nxt.msg_asrt     = st.us_agg[ws];
            st_nxt.msg_wire     = 2'(ws);
            st_nxt.us_sent[ws]  = st.us_agg[ws];
        end

        // Every MSI goes upstream whatever its address
        st_nxt.msi = 1'b0;
        for (int p = NUM_DS - 1; p >= 0; p--) begin
            if (st.msi_pend[p]) begin
                ps = p;
            end
        end
        st_nxt.msi_pend = st.msi_pend;
        if (|st.msi_pend) begin
            st_nxt.msi          = 1'b1;
            st_nxt.msi_port     = 2'(ps);
            st_nxt.msi_pend[ps] = 1'b0;
        end
        st_nxt.msi_pend = st_nxt.msi_pend | msi_fire;

        ev            = '0;
        ev[EV_MSI]    = st_nxt.msi;
        ev[EV_ASSERT] = st_nxt.msg & st_nxt.msg_asrt;
        ev[EV_DEASRT] = st_nxt.msg & ~st_nxt.msg_asrt;
        ev[EV_LINKDN] = |(st.link & ~dl_up_i);
        st_nxt.ev_sts = (st.ev_sts & ~rd_clr) | ev;
        st_nxt.irq    = |(st_nxt.ev_sts & st_nxt.ev_en);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st       <= '0;
            st.ctrl  <= {NUM_DS{CTRL_RST}};
            st.ev_en <= IRQ_EN_RST;
        end else begin
            st <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata_o      = st.prdata;
    assign pready_o      = st.apb[0];
    assign pslverr_o     = st.slverr;
    assign msi_req_o     = st.msi;
    assign msi_port_o    = st.msi_port;
    assign intx_msg_o    = st.msg;
    assign intx_assert_o = st.msg_asrt;
    assign intx_wire_o   = st.msg_wire;
    assign ds_intx_o     = st.port_wire;
    assign us_intx_o     = st.us_agg;
    assign irq_o         = st.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_msg_follows;
        diff != '0 |=> st.msg;
    endproperty
    a_msg_follows: assert property (p_msg_follows) else $error("Wire change not reported");

    property p_msg_dir;
        st.msg |-> st.msg_asrt == st.us_sent[st.msg_wire];
    endproperty
    a_msg_dir: assert property (p_msg_dir) else $error("Message kind wrong");

    property p_msg_only_change;
        !st.msg ##1 st.msg |-> $past(diff) != '0;
    endproperty
    a_msg_only_change: assert property (p_msg_only_change) else $error("Spurious message");

    property p_remap_dev1;
        dl_up_i[1] && ext_intx_i[1][0] |=> ##1 st.us_agg[1];
    endproperty
    a_remap_dev1: assert property (p_remap_dev1) else $error("Device 1 INTA not on INTB");

    property p_own_or;
        us_own_intx_i[3] |=> st.us_agg[3];
    endproperty
    a_own_or: assert property (p_own_or) else $error("Own upstream wire lost");

    property p_link_neg;
        !dl_up_i[3] |=> st.port_wire[3] == '0;
    endproperty
    a_link_neg: assert property (p_link_neg) else $error("Wires kept on link down");

    property p_msi_fwd;
        msi_fire[1] |=> st.msi_pend[1] ##[0:4] st.msi && st.msi_port == 2'd1;
    endproperty
    a_msi_fwd: assert property (p_msi_fwd) else $error("MSI not forwarded");

    property p_irq_level;
        ##1 irq_o == |(st.ev_sts & st.ev_en);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

    c_msi:    cover property (st.msi);
    c_assert: cover property (st.msg && st.msg_asrt);
    c_deasrt: cover property (st.msg && !st.msg_asrt);
    c_irq:    cover property ($rose(st.irq));
endmodule

// ===== testbench/spirq_root_model.sv
/*
 Behavioural root complex seen through the upstream port: counts MSIs and
 tracks the virtual wire state that the Assert/Deassert messages build up.
 Assumes messages are pulses that the root must take in the same cycle.
*/
`timescale 1ns/100ps
module spirq_root_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       msi_req_i,
    input  wire logic       intx_msg_i,
    input  wire logic       intx_assert_i,
    input  wire logic [1:0] intx_wire_i,
    output logic      [3:0] wire_state_o,
    output logic      [7:0] msi_cnt_o,
    output logic      [7:0] msg_cnt_o,
    output logic            proto_err_o
);
    // ********************************
    // Message sink
    // ********************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wire_state_o <= 4'h0;
            msi_cnt_o    <= 8'h00;
            msg_cnt_o    <= 8'h00;
            proto_err_o  <= 1'b0;
        end else begin
            if (msi_req_i) begin
                msi_cnt_o <= msi_cnt_o + 8'h01;
            end
            if (intx_msg_i) begin
                msg_cnt_o <= msg_cnt_o + 8'h01;
                // A repeated Assert or Deassert means a missed edge upstream
                if (wire_state_o[intx_wire_i] == intx_assert_i) begin
                    proto_err_o <= 1'b1;
                end
                wire_state_o[intx_wire_i] <= intx_assert_i;
            end
        end
    end
endmodule

// ===== testbench/spirq_top_tb_top.sv
/*
 Self-checking bench of the switch interrupt signalling block.
 Assumes the APB slave answers in two access cycles and pulses are one cycle.
*/
`timescale 1ns/100ps
module spirq_top_tb_top;
    import spirq_pkg::*;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0000_0000;
    logic [31:0]     prdata_o;
    logic            pready_o;
    logic            pslverr_o;
    logic [3:0]      hp = 4'h0;
    logic [3:0]      bw = 4'h0;
    logic [3:0]      abw = 4'h0;
    logic [3:0]      dl_up = 4'hf;
    logic [3:0][3:0] ext = 16'h0000;
    logic [3:0]      own = 4'h0;
    logic            msi_req_o;
    logic [1:0]      msi_port_o;
    logic            intx_msg_o;
    logic            intx_assert_o;
    logic [1:0]      intx_wire_o;
    logic [15:0]     ds_intx_o;
    logic [3:0]      us_intx_o;
    logic            irq_o;
    logic [3:0]      root_wires;
    logic [7:0]      root_msi;
    logic [7:0]      root_msgs;
    logic            root_err;
    int              err_total = 0;
    int              checks = 0;
    int              cyc = 0;
    logic [31:0]     rdv;
    logic            erv;

    always #10 ref_clk = ~ref_clk;

    spirq_top spirq_top_inst (.ref_clk_i(ref_clk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .hp_evt_i(hp),
        .bw_mgmt_flag_i(bw), .autonomous_bw_flag_i(abw), .dl_up_i(dl_up),
        .ext_intx_i(ext), .us_own_intx_i(own), .msi_req_o(msi_req_o),
        .msi_port_o(msi_port_o), .intx_msg_o(intx_msg_o), .intx_assert_o(intx_assert_o),
        .intx_wire_o(intx_wire_o), .ds_intx_o(ds_intx_o), .us_intx_o(us_intx_o),
        .irq_o(irq_o));

    spirq_root_model spirq_root_model_inst (.ref_clk_i(ref_clk), .rst_i(rst),
        .msi_req_i(msi_req_o), .intx_msg_i(intx_msg_o), .intx_assert_i(intx_assert_o),
        .intx_wire_i(intx_wire_o), .wire_state_o(root_wires), .msi_cnt_o(root_msi),
        .msg_cnt_o(root_msgs), .proto_err_o(root_err));

    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the slave's answer
        do begin
            @(posedge ref_clk);
        end while (pready_o !== 1'b1);
        rdv = prdata_o;
        erv = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wait_msg(input logic a, input logic [1:0] w);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (intx_msg_o !== 1'b1 && n < 20);
        chk({31'h0, intx_msg_o}, 32'h0000_0001);
        chk({31'h0, intx_assert_o}, {31'h0, a});
        chk({30'h0, intx_wire_o}, {30'h0, w});
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset_map;
        for (int p = 0; p < 4; p++) begin
            apb(1'b0, 8'(p) * PORT_STRIDE + OFS_PCTRL, 32'h0);
            chk(rdv, 32'h0000_0000);
        end
        apb(1'b0, OFS_IRQ_EN, 32'h0);
        chk(rdv, 32'h0000_0000);
        apb(1'b0, 8'h4c, 32'h0);
        chk({31'h0, erv}, 32'h0000_0001);
        chk(rdv, 32'h0000_0000);
    endtask

    task automatic t_msi;
        int n;
        n = 0;
        // Message enable wins over legacy disable; address routing is software's job
        apb(1'b1, PORT_STRIDE + OFS_PCTRL, 32'h0000_0007);
        @(posedge ref_clk) hp[1] <= 1'b1;
        @(posedge ref_clk) hp[1] <= 1'b0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (msi_req_o !== 1'b1 && n < 20);
        chk({30'h0, msi_port_o}, 32'h0000_0001);
        idle(3);
        chk({24'h0, root_msi}, 32'h0000_0001);
        chk({24'h0, root_msgs}, 32'h0000_0000);
        apb(1'b1, PORT_STRIDE + OFS_PSTS, 32'h0000_0001);
        idle(8);
        chk({24'h0, root_msi}, 32'h0000_0001);
    endtask

    task automatic t_legacy_off;
        apb(1'b1, OFS_PCTRL, 32'h0000_0006);
        @(posedge ref_clk) hp[0] <= 1'b1;
        @(posedge ref_clk) hp[0] <= 1'b0;
        idle(10);
        chk({28'h0, ds_intx_o[3:0]}, 32'h0000_0000);
        chk({24'h0, root_msgs}, 32'h0000_0000);
        apb(1'b1, OFS_PCTRL, 32'h0000_0000);
        apb(1'b1, OFS_PSTS, 32'h0000_0001);
    endtask

    task automatic t_own_inta;
        apb(1'b1, 8'h20 + OFS_PCTRL, 32'h0000_0008);
        @(posedge ref_clk) bw[2] <= 1'b1;
        @(posedge ref_clk) bw[2] <= 1'b0;
        wait_msg(1'b1, 2'd2);
        chk({28'h0, ds_intx_o[11:8]}, 32'h0000_0001);
        apb(1'b1, 8'h20 + OFS_PCTRL, 32'h0000_0000);
        wait_msg(1'b0, 2'd2);
        apb(1'b1, 8'h20 + OFS_PSTS, 32'h0000_0002);
        apb(1'b1, 8'h20 + OFS_PCTRL, 32'h0000_0010);
        @(posedge ref_clk) abw[2] <= 1'b1;
        @(posedge ref_clk) abw[2] <= 1'b0;
        wait_msg(1'b1, 2'd2);
        apb(1'b1, 8'h20 + OFS_PSTS, 32'h0000_0004);
        wait_msg(1'b0, 2'd2);
        apb(1'b1, 8'h20 + OFS_PCTRL, 32'h0000_0000);
    endtask

    task automatic t_remap_or;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) ext[1][i] <= 1'b1;
            wait_msg(1'b1, 2'((i + 1) % 4));
            chk({28'h0, ds_intx_o[7:4]}, 32'(1 << i));
            @(posedge ref_clk) ext[1][i] <= 1'b0;
            wait_msg(1'b0, 2'((i + 1) % 4));
        end
        // The upstream port's own wire keeps the aggregate up after the device drops
        @(posedge ref_clk) ext[3][0] <= 1'b1;
        wait_msg(1'b1, 2'd3);
        @(posedge ref_clk) own[3] <= 1'b1;
        @(posedge ref_clk) ext[3][0] <= 1'b0;
        idle(10);
        chk({28'h0, us_intx_o}, 32'h0000_0008);
        chk({28'h0, root_wires}, 32'h0000_0008);
        @(posedge ref_clk) own[3] <= 1'b0;
        wait_msg(1'b0, 2'd3);
    endtask

    task automatic t_link_irq;
        apb(1'b0, OFS_IRQ_STS, 32'h0);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_000a);
        @(posedge ref_clk) ext[3][1] <= 1'b1;
        wait_msg(1'b1, 2'd0);
        idle(2);
        chk({31'h0, irq_o}, 32'h0000_0001);
        apb(1'b0, OFS_AGG, 32'h0);
        chk(rdv, 32'h0002_0001);
        apb(1'b0, OFS_IRQ_STS, 32'h0);
        chk(rdv, 32'h0000_0002);
        idle(2);
        chk({31'h0, irq_o}, 32'h0000_0000);
        @(posedge ref_clk) dl_up[3] <= 1'b0;
        wait_msg(1'b0, 2'd0);
        chk({28'h0, ds_intx_o[15:12]}, 32'h0000_0000);
        idle(2);
        chk({31'h0, irq_o}, 32'h0000_0001);
        apb(1'b0, OFS_IRQ_STS, 32'h0);
        chk(rdv, 32'h0000_000c);
        @(posedge ref_clk) ext[3][1] <= 1'b0;
        @(posedge ref_clk) dl_up[3] <= 1'b1;
        idle(10);
        chk({31'h0, irq_o}, 32'h0000_0000);
        chk({31'h0, root_err}, 32'h0000_0000);
    endtask

    // Hang guard well above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_map();
        t_msi();
        t_legacy_off();
        t_own_inta();
        t_remap_or();
        t_link_irq();
        print_verdict();
    end
endmodule
